// ===== hdl/tac_alarm_top.sv
// Alarm, fail-safe and interrupt logic of the two-channel temperature monitor
`timescale 1ns/1ps
module tac_alarm_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic conv_start,
    input wire tac_pkg::tac_byte_t local_result,
    input wire logic local_valid,
    input wire tac_pkg::tac_byte_t remote_raw,
    input wire logic remote_valid,
    input wire logic open_cmp_pin,
    input wire logic ara_read,
    output logic ara_ack,
    output tac_pkg::tac_byte_t ara_data,
    output logic alert_shared_out_n,
    output logic alert_shared_oe_n,
    output logic failsafe_overtemp_out_n,
    output logic failsafe_overtemp_oe_n,
    output logic irq
);
    import tac_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic addr_ph;
    logic addr_ok;
    logic wr_pend_q;
    tac_byte_t wr_addr_q;
    logic [31:0] hrdata_q;
    logic [31:0] rd_d;
    logic wr_en;
    tac_byte_t wdat;

    logic [1:0] ctrl_q;
    logic [6:0] irq_mask_q;
    logic [6:0] status_q;
    logic [6:0] status_set;
    logic [6:0] status_clr;
    tac_lim_t lim_q [2];
    tac_byte_t hyst_q;
    tac_byte_t offset_q;
    tac_byte_t val_q [2];
    logic [1:0] eval_q;
    logic [1:0] fs_q;
    logic [1:0] fs2_q;
    tac_cmp_t cmp [2];
    logic lim_wr;

    logic signed [9:0] rem_sum;
    tac_byte_t rem_adj;

    logic open_meta_q;
    logic open_sync_q;

    logic alarm_cause;
    logic cond_live;
    logic alarm_en;
    logic alarm_q;
    logic shared_drive;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave: zero wait state, always OKAY

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    // Only word transfers are issued, so hsize needs no lane steering
    assign addr_ph = hsel && hready && htrans[1];
    assign addr_ok = haddr[31:8] == 24'h000000;
    assign wr_en = wr_pend_q;
    assign wdat = hwdata[7:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= addr_ph && hwrite && addr_ok && (hsize == 3'h2);
            if (addr_ph) begin
                wr_addr_q <= haddr[7:0];
            end
        end
    end

    // Read data is picked in the address phase so it stands from a flop
    always_comb begin
        rd_d = 32'h00000000;
        if (addr_ok) begin
            unique case (haddr[7:0])
                TAC_OFF_CTRL: rd_d = {30'h00000000, ctrl_q};
                TAC_OFF_STATUS: rd_d = {25'h0000000, status_q};
                TAC_OFF_IRQ_MASK: rd_d = {25'h0000000, irq_mask_q};
                TAC_OFF_LOC_HIGH: rd_d = {24'h000000, lim_q[0].high};
                TAC_OFF_LOC_LOW: rd_d = {24'h000000, lim_q[0].low};
                TAC_OFF_LOC_FS: rd_d = {24'h000000, lim_q[0].fs};
                TAC_OFF_REM_HIGH: rd_d = {24'h000000, lim_q[1].high};
                TAC_OFF_REM_LOW: rd_d = {24'h000000, lim_q[1].low};
                TAC_OFF_REM_FS: rd_d = {24'h000000, lim_q[1].fs};
                TAC_OFF_HYST: rd_d = {24'h000000, hyst_q};
                TAC_OFF_OFFSET: rd_d = {24'h000000, offset_q};
                TAC_OFF_LOC_VAL: rd_d = {24'h000000, val_q[0]};
                TAC_OFF_REM_VAL: rd_d = {24'h000000, val_q[1]};
                default: rd_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h00000000;
        end else if (addr_ph && !hwrite) begin
            hrdata_q <= rd_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= TAC_CTRL_RST;
            irq_mask_q <= TAC_MASK_RST;
            hyst_q <= TAC_HYST_RST;
            offset_q <= TAC_OFFSET_RST;
        end else if (wr_en) begin
            unique case (wr_addr_q)
                TAC_OFF_CTRL: ctrl_q <= wdat[1:0];
                TAC_OFF_IRQ_MASK: irq_mask_q <= wdat[6:0];
                TAC_OFF_HYST: hyst_q <= wdat;
                TAC_OFF_OFFSET: offset_q <= wdat;
                default: ;
            endcase
        end
    end

    // No check against the high limits; ordering is left to software
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int c = 0; c < 2; c++) begin
                lim_q[c] <= '{high: TAC_HIGH_RST, low: TAC_LOW_RST, fs: TAC_FS_RST};
            end
        end else if (wr_en) begin
            unique case (wr_addr_q)
                TAC_OFF_LOC_HIGH: lim_q[0].high <= wdat;
                TAC_OFF_LOC_LOW: lim_q[0].low <= wdat;
                TAC_OFF_LOC_FS: lim_q[0].fs <= wdat;
                TAC_OFF_REM_HIGH: lim_q[1].high <= wdat;
                TAC_OFF_REM_LOW: lim_q[1].low <= wdat;
                TAC_OFF_REM_FS: lim_q[1].fs <= wdat;
                default: ;
            endcase
        end
    end

    // Any limit or hysteresis write re-runs both comparisons
    assign lim_wr = wr_en && (wr_addr_q >= TAC_OFF_LOC_HIGH) && (wr_addr_q <= TAC_OFF_HYST);

    ////////////////////////////////////////////////////////////////////////////////
    // Value registers with remote calibration offset

    // Offset is signed; result saturates instead of wrapping
    assign rem_sum = $signed({2'b00, remote_raw}) + $signed({{2{offset_q[7]}}, offset_q});
    assign rem_adj = (rem_sum < 0) ? 8'h00 : (rem_sum > 10'sd255) ? 8'hFF : rem_sum[7:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            val_q[0] <= 8'h00;
            val_q[1] <= 8'h00;
        end else begin
            if (local_valid) begin
                val_q[0] <= local_result;
            end
            if (remote_valid) begin
                val_q[1] <= rem_adj;
            end
        end
    end

    // Compare one cycle after the store, against the limits of that moment
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            eval_q <= 2'h0;
        end else begin
            eval_q[0] <= local_valid || lim_wr;
            eval_q[1] <= remote_valid || lim_wr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-channel comparison and fail-safe state

    genvar gc;
    generate
        for (gc = 0; gc < 2; gc++) begin : g_chan
            tac_chan_cmp u_cmp (
                .value(val_q[gc]),
                .lim(lim_q[gc]),
                .hyst(hyst_q),
                .fs_act(fs_q[gc]),
                .fs2_act(fs2_q[gc]),
                .res(cmp[gc])
            );

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    fs_q[gc] <= 1'b0;
                    fs2_q[gc] <= 1'b0;
                end else if (eval_q[gc]) begin
                    fs_q[gc] <= cmp[gc].fs;
                    fs2_q[gc] <= cmp[gc].fs2;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Open-diode comparator

    // Analog comparator is asynchronous to hclk
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            open_meta_q <= 1'b0;
            open_sync_q <= 1'b0;
        end else begin
            open_meta_q <= open_cmp_pin;
            open_sync_q <= open_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status register, write one to clear, set wins

    always_comb begin
        status_set = 7'h00;
        status_set[TAC_ST_OPEN] = conv_start && open_sync_q;
        if (eval_q[0]) begin
            status_set[TAC_ST_LOC_HIGH] = cmp[0].high;
            status_set[TAC_ST_LOC_LOW] = cmp[0].low;
            status_set[TAC_ST_LOC_FS] = cmp[0].fs;
        end
        if (eval_q[1]) begin
            status_set[TAC_ST_REM_HIGH] = cmp[1].high;
            status_set[TAC_ST_REM_LOW] = cmp[1].low;
            status_set[TAC_ST_REM_FS] = cmp[1].fs;
        end
    end

    assign status_clr = (wr_en && wr_addr_q == TAC_OFF_STATUS) ? wdat[6:0] : 7'h00;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_q <= 7'h00;
        end else begin
            status_q <= (status_q & ~status_clr) | status_set;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_q & irq_mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Alarm and alert response

    // Fail-safe flags are kept out of the alarm sources
    assign alarm_cause = |(status_q & TAC_ST_ALARM_SRC) && !ctrl_q[TAC_CTRL_MASK_BIT];
    assign cond_live = cmp[0].high || cmp[0].low || cmp[1].high || cmp[1].low || open_sync_q;
    assign alarm_en = !ctrl_q[TAC_CTRL_PIN_MODE_BIT];

    tac_ara_resp u_ara (
        .hclk(hclk),
        .hresetn(hresetn),
        .cause(alarm_cause),
        .cond_live(cond_live),
        .enable(alarm_en),
        .ara_read(ara_read),
        .alarm_q(alarm_q),
        .ara_ack_q(ara_ack),
        .ara_data_q(ara_data)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Open-drain pins: output low, enable low while pulling

    assign shared_drive = alarm_en ? alarm_q : (|fs2_q);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alert_shared_out_n <= 1'b0;
            alert_shared_oe_n <= 1'b1;
            failsafe_overtemp_out_n <= 1'b0;
            failsafe_overtemp_oe_n <= 1'b1;
        end else begin
            alert_shared_out_n <= 1'b0;
            alert_shared_oe_n <= !shared_drive;
            failsafe_overtemp_out_n <= 1'b0;
            // No mask term reaches the fail-safe pin
            failsafe_overtemp_oe_n <= !(|fs_q);
        end
    end

endmodule

// ===== hdl/tac_pkg.sv
// Constants, types and register map of the temperature alarm block
//
// What this block does
// - At each conversion start, sample the open-diode comparator; set status bit 2.
// - With the alarm function enabled, a set open flag pulls the alarm low.
// - Alarm is maskable; only limit violations and the open fault drive it.
// - Fail-safe output ignores every alarm mask and follows its comparison.
// - Alarm asserts for temperature above high limit or at/below low limit.
// - Alarm releases on alert response read, condition gone, status cleared.
// - Fail-safe output low while either channel is above its fail-safe limit.
// - Fail-safe releases alone once temperature falls to limit minus hysteresis.
// - Hysteresis resets to ten degrees, unsigned whole degrees, reprogrammable.
// - Shared pin selects either maskable alarm or second fail-safe output.
// - Second fail-safe goes low above high limits, unmaskable, self-releasing.
// - Hysteresis also sets second fail-safe release point against high limits.
// - Both channels feed both fail-safe comparisons; either one asserts.
// - Signed offset is added to the remote result before storing and comparing.
// - Alert response read answers own 7-bit address with LSB one appended.
// - Writing limits re-evaluates stored values and may raise the alarm.
package tac_pkg;

    typedef logic [7:0] tac_byte_t;

    typedef struct packed {
        tac_byte_t high;
        tac_byte_t low;
        tac_byte_t fs;
    } tac_lim_t;

    typedef struct packed {
        logic high;
        logic low;
        logic fs;
        logic fs2;
    } tac_cmp_t;

    // Register byte offsets
    localparam logic [7:0] TAC_OFF_CTRL = 8'h00;
    localparam logic [7:0] TAC_OFF_STATUS = 8'h04;
    localparam logic [7:0] TAC_OFF_IRQ_MASK = 8'h08;
    localparam logic [7:0] TAC_OFF_LOC_HIGH = 8'h0C;
    localparam logic [7:0] TAC_OFF_LOC_LOW = 8'h10;
    localparam logic [7:0] TAC_OFF_LOC_FS = 8'h14;
    localparam logic [7:0] TAC_OFF_REM_HIGH = 8'h18;
    localparam logic [7:0] TAC_OFF_REM_LOW = 8'h1C;
    localparam logic [7:0] TAC_OFF_REM_FS = 8'h20;
    localparam logic [7:0] TAC_OFF_HYST = 8'h24;
    localparam logic [7:0] TAC_OFF_OFFSET = 8'h28;
    localparam logic [7:0] TAC_OFF_LOC_VAL = 8'h2C;
    localparam logic [7:0] TAC_OFF_REM_VAL = 8'h30;

    // Control fields
    localparam int TAC_CTRL_MASK_BIT = 0;
    localparam int TAC_CTRL_PIN_MODE_BIT = 1;

    // Status fields, one layout for status and interrupt mask
    localparam int TAC_ST_W = 7;
    localparam int TAC_ST_LOC_FS = 0;
    localparam int TAC_ST_REM_FS = 1;
    localparam int TAC_ST_OPEN = 2;
    localparam int TAC_ST_REM_LOW = 3;
    localparam int TAC_ST_REM_HIGH = 4;
    localparam int TAC_ST_LOC_LOW = 5;
    localparam int TAC_ST_LOC_HIGH = 6;
    localparam logic [6:0] TAC_ST_ALARM_SRC = 7'h7C;

    // Reset values
    localparam logic [1:0] TAC_CTRL_RST = 2'h0;
    localparam logic [6:0] TAC_MASK_RST = 7'h00;
    localparam tac_byte_t TAC_HIGH_RST = 8'h55;
    localparam tac_byte_t TAC_LOW_RST = 8'h00;
    localparam tac_byte_t TAC_FS_RST = 8'h55;
    localparam tac_byte_t TAC_HYST_RST = 8'h0A;
    localparam tac_byte_t TAC_OFFSET_RST = 8'h00;

    // Own bus address, arbitrary value
    localparam logic [6:0] TAC_DEV_ADDR = 7'h2A;

endpackage

// ===== hdl/tac_chan_cmp.sv
// Limit comparison of one temperature channel
`timescale 1ns/1ps
module tac_chan_cmp (
    input wire tac_pkg::tac_byte_t value,
    input wire tac_pkg::tac_lim_t lim,
    input wire tac_pkg::tac_byte_t hyst,
    input wire logic fs_act,
    input wire logic fs2_act,
    output tac_pkg::tac_cmp_t res
);
    import tac_pkg::*;

    logic signed [9:0] val_s;
    logic signed [9:0] fs_rel;
    logic signed [9:0] hi_rel;

    // Signed room so a hysteresis above the limit cannot wrap
    assign val_s = $signed({2'b00, value});
    assign fs_rel = $signed({2'b00, lim.fs}) - $signed({2'b00, hyst});
    assign hi_rel = $signed({2'b00, lim.high}) - $signed({2'b00, hyst});

    always_comb begin
        res.high = value > lim.high;
        // At or below the low limit
        res.low = value <= lim.low;
        res.fs = fs_act ? (val_s > fs_rel) : (value > lim.fs);
        res.fs2 = fs2_act ? (val_s > hi_rel) : (value > lim.high);
    end

endmodule

// ===== hdl/tac_ara_resp.sv
// Alarm latch and alert response answer
`timescale 1ns/1ps
module tac_ara_resp (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic cause,
    input wire logic cond_live,
    input wire logic enable,
    input wire logic ara_read,
    output logic alarm_q,
    output logic ara_ack_q,
    output tac_pkg::tac_byte_t ara_data_q
);
    import tac_pkg::*;

    logic release_ok;

    // Release needs the service read, a cleared status and no live cause
    assign release_ok = ara_read && !cause && !cond_live;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alarm_q <= 1'b0;
        end else if (cause && enable) begin
            alarm_q <= 1'b1;
        end else if (release_ok || !enable) begin
            alarm_q <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ara_ack_q <= 1'b0;
            ara_data_q <= 8'h00;
        end else begin
            ara_ack_q <= ara_read && alarm_q && enable;
            if (ara_read && alarm_q && enable) begin
                ara_data_q <= {TAC_DEV_ADDR, 1'b1};
            end
        end
    end

endmodule

// ===== bench/tac_alarm_chk.sv
// Port checker of the temperature alarm block
`timescale 1ns/1ps
module tac_alarm_chk
    import tac_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic conv_start,
    input wire logic local_valid,
    input wire logic remote_valid,
    input wire logic ara_read,
    input wire logic ara_ack,
    input wire tac_pkg::tac_byte_t ara_data,
    input wire logic alert_shared_out_n,
    input wire logic alert_shared_oe_n,
    input wire logic failsafe_overtemp_out_n,
    input wire logic failsafe_overtemp_oe_n,
    input wire logic irq
);
    logic quiet;
    logic quiet_st;
    // Limit and hysteresis writes re-run the comparisons, so bus traffic counts as activity
    assign quiet = !local_valid && !remote_valid && !(hsel && htrans[1]);
    assign quiet_st = quiet && !conv_start;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    ////////////////////////////////////////////////////////////////////////////
    property p_drive_zero;
        !alert_shared_out_n && !failsafe_overtemp_out_n;
    endproperty
    a_drive_zero: assert property (p_drive_zero)
        else $error("open drain value not low");
    property p_ack_one;
        ara_ack |=> !ara_ack;
    endproperty
    a_ack_one: assert property (p_ack_one)
        else $error("alert answer longer than one cycle");
    property p_ack_cause;
        ara_ack |-> $past(ara_read) && !$past(alert_shared_oe_n);
    endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("alert answer without request or alarm");
    property p_ack_data;
        ara_ack |-> ara_data == {TAC_DEV_ADDR, 1'b1};
    endproperty
    a_ack_data: assert property (p_ack_data)
        else $error("alert answer carries wrong address");
    property p_quiet_fs;
        quiet [*5] |=> $stable(failsafe_overtemp_oe_n);
    endproperty
    a_quiet_fs: assert property (p_quiet_fs)
        else $error("fail-safe pin moved without new result");
    property p_quiet_irq;
        quiet_st [*5] |=> $stable(irq);
    endproperty
    a_quiet_irq: assert property (p_quiet_irq)
        else $error("interrupt moved without cause");
    property p_quiet_alarm;
        (quiet_st && !ara_read) [*5] |=> $stable(alert_shared_oe_n);
    endproperty
    a_quiet_alarm: assert property (p_quiet_alarm)
        else $error("alarm pin moved without cause");
    property p_unmapped;
        hsel && hready && htrans[1] && !hwrite && haddr[31:8] != 24'h0 |=> hrdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
endmodule

// ===== bench/tac_smbus_host.sv
// Alert servicing host model of the far side
`timescale 1ns/1ps
module tac_smbus_host (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic svc_en,
    input wire logic slow,
    input wire logic alert_n,
    input wire logic ara_ack,
    input wire tac_pkg::tac_byte_t ara_data,
    output logic ara_read,
    output int acks,
    output tac_pkg::tac_byte_t last_addr
);
    import tac_pkg::*;
    int gap;
    // Gap lets the pin settle after a read; a pin still low is serviced again once the gap of 6 or 40 cycles has run out
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ara_read <= 1'b0;
            gap <= 0;
            acks <= 0;
            last_addr <= 8'h00;
        end else begin
            ara_read <= 1'b0;
            if (gap > 0) begin
                gap <= gap - 1;
            end else if (svc_en && !alert_n) begin
                ara_read <= 1'b1;
                gap <= slow ? 40 : 6;
            end
            if (ara_ack) begin
                acks <= acks + 1;
                last_addr <= ara_data;
            end
        end
    end
endmodule

// ===== bench/tac_alarm_top_tb_top.sv
// Testbench of the temperature alarm block
`timescale 1ns/1ps
module tac_alarm_top_tb_top;
    import tac_pkg::*;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hresp;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic conv_start = 1'b0, local_valid = 1'b0, remote_valid = 1'b0, open_cmp_pin = 1'b0;
    logic ara_read, ara_ack, irq, sh_out_n, sh_oe_n, fs_out_n, fs_oe_n, alert_n;
    logic svc_en = 1'b0, slow = 1'b0;
    tac_byte_t local_result = 8'h00, remote_raw = 8'h00, ara_data, last_addr;
    int acks, a0, fail_count = 0, total_checks = 0;
    always #2.5 hclk = ~hclk;
    // Pulled-up alarm line
    assign alert_n = sh_oe_n ? 1'b1 : sh_out_n;
    tac_alarm_top i_tac_alarm_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .conv_start(conv_start),
        .local_result(local_result), .local_valid(local_valid), .remote_raw(remote_raw),
        .remote_valid(remote_valid), .open_cmp_pin(open_cmp_pin), .ara_read(ara_read),
        .ara_ack(ara_ack), .ara_data(ara_data), .alert_shared_out_n(sh_out_n),
        .alert_shared_oe_n(sh_oe_n), .failsafe_overtemp_out_n(fs_out_n),
        .failsafe_overtemp_oe_n(fs_oe_n), .irq(irq));
    tac_smbus_host i_tac_smbus_host (.hclk(hclk), .hresetn(hresetn), .svc_en(svc_en),
        .slow(slow), .alert_n(alert_n), .ara_ack(ara_ack), .ara_data(ara_data),
        .ara_read(ara_read), .acks(acks), .last_addr(last_addr));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        @(posedge hclk);
        while (hready !== 1'b1 && n < 50) begin
            @(posedge hclk);
            n++;
        end
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1 && n < 100) begin
            @(posedge hclk);
            n++;
        end
        rd = hrdata;
        if (n >= 100) fail_count++;
    endtask
    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic send(input logic rem, input tac_byte_t v);
        if (rem) begin
            remote_raw <= v;
            remote_valid <= 1'b1;
        end else begin
            local_result <= v;
            local_valid <= 1'b1;
        end
        @(posedge hclk);
        remote_valid <= 1'b0;
        local_valid <= 1'b0;
        waitc(4);
    endtask
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        fail_count++;
        close_out();
    end
    initial begin
        waitc(10);
        hresetn <= 1'b1;
        waitc(1);
        rdchk(TAC_OFF_HYST, 32'h0A);
        rdchk(TAC_OFF_LOC_HIGH, 32'h55);
        rdchk(TAC_OFF_REM_FS, 32'h55);
        rdchk(TAC_OFF_STATUS, 32'h0);
        rdchk(32'h100, 32'h0);
        chk(hresp, 32'h0);
        $display("Test reset done");
        send(1'b0, 8'h30);
        xfer(1'b1, TAC_OFF_OFFSET, 32'hFE);
        send(1'b1, 8'h58);
        rdchk(TAC_OFF_REM_VAL, 32'h56);
        chk(sh_oe_n, 32'h0);
        chk(fs_oe_n, 32'h0);
        chk(irq, 32'h0);
        xfer(1'b1, TAC_OFF_IRQ_MASK, 32'h10);
        waitc(3);
        chk(irq, 32'h1);
        send(1'b1, 8'h4E);
        chk(fs_oe_n, 32'h0);
        send(1'b1, 8'h4D);
        chk(fs_oe_n, 32'h1);
        slow <= 1'b1;
        svc_en <= 1'b1;
        waitc(60);
        chk(sh_oe_n, 32'h0);
        chk(acks > 0, 32'h1);
        chk(last_addr, {TAC_DEV_ADDR, 1'b1});
        xfer(1'b1, TAC_OFF_STATUS, 32'h7F);
        waitc(3);
        chk(irq, 32'h0);
        waitc(90);
        chk(sh_oe_n, 32'h1);
        slow <= 1'b0;
        $display("Test remote alarm done");
        xfer(1'b1, TAC_OFF_HYST, 32'h02);
        rdchk(TAC_OFF_HYST, 32'h02);
        send(1'b0, 8'h56);
        chk(fs_oe_n, 32'h0);
        send(1'b0, 8'h54);
        chk(fs_oe_n, 32'h0);
        send(1'b0, 8'h53);
        chk(fs_oe_n, 32'h1);
        xfer(1'b1, TAC_OFF_STATUS, 32'h7F);
        waitc(20);
        chk(sh_oe_n, 32'h1);
        send(1'b0, 8'h00);
        rdchk(TAC_OFF_STATUS, 32'h20);
        chk(sh_oe_n, 32'h0);
        send(1'b0, 8'h30);
        xfer(1'b1, TAC_OFF_STATUS, 32'h7F);
        waitc(20);
        chk(sh_oe_n, 32'h1);
        $display("Test hysteresis done");
        xfer(1'b1, TAC_OFF_CTRL, 32'h1);
        send(1'b0, 8'h56);
        chk(sh_oe_n, 32'h1);
        chk(fs_oe_n, 32'h0);
        send(1'b0, 8'h30);
        xfer(1'b1, TAC_OFF_STATUS, 32'h7F);
        xfer(1'b1, TAC_OFF_CTRL, 32'h2);
        a0 = acks;
        send(1'b0, 8'h56);
        waitc(20);
        chk(sh_oe_n, 32'h0);
        chk(acks, a0);
        send(1'b0, 8'h54);
        chk(sh_oe_n, 32'h0);
        send(1'b0, 8'h53);
        chk(sh_oe_n, 32'h1);
        $display("Test pin modes done");
        xfer(1'b1, TAC_OFF_CTRL, 32'h0);
        xfer(1'b1, TAC_OFF_STATUS, 32'h7F);
        // Stale alarm released first, so only the open flag can pull the pin
        waitc(20);
        chk(sh_oe_n, 32'h1);
        open_cmp_pin <= 1'b1;
        waitc(3);
        conv_start <= 1'b1;
        waitc(1);
        conv_start <= 1'b0;
        waitc(3);
        rdchk(TAC_OFF_STATUS, 32'h04);
        chk(sh_oe_n, 32'h0);
        open_cmp_pin <= 1'b0;
        waitc(3);
        xfer(1'b1, TAC_OFF_STATUS, 32'h7F);
        waitc(20);
        chk(sh_oe_n, 32'h1);
        xfer(1'b1, TAC_OFF_LOC_HIGH, 32'h20);
        waitc(4);
        rdchk(TAC_OFF_STATUS, 32'h40);
        $display("Test open fault and limit write done");
        close_out();
    end
endmodule
bind tac_alarm_top tac_alarm_chk i_tac_alarm_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .conv_start(conv_start), .local_valid(local_valid), .remote_valid(remote_valid),
    .ara_read(ara_read), .ara_ack(ara_ack), .ara_data(ara_data),
    .alert_shared_out_n(alert_shared_out_n), .alert_shared_oe_n(alert_shared_oe_n),
    .failsafe_overtemp_out_n(failsafe_overtemp_out_n),
    .failsafe_overtemp_oe_n(failsafe_overtemp_oe_n), .irq(irq));
